// ===== hw/mct_timer.sv
// counter/timer with prescaler, four matches, two captures, ahb-lite slave
// assumes pins are asynchronous to hclk and the bus master is single word
//
// How it works
// - counter advances on prescaled system clock
// - loadable prescaler, counter width, gates counting
// - mode selects timer or external edge counting
// - four match registers compared against count
// - match may continue, irq if enabled
// - match may stop counter and prescaler
// - match may reset counter to zero
// - match outputs go low, high, toggle, hold
// - capture edge copies count into register
// - per channel capture interrupt enable
// - capture event may clear counter, prescaler
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mct_timer
  import mct_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  cap_in,
  input  wire logic        count_in,
  output logic [3:0]       match_out,
  output logic             irq
);
  // registers
  logic [1:0]   ctrl_q;
  logic [W-1:0] count_q;
  logic [W-1:0] psc_q;
  logic [W-1:0] pcnt_q;
  logic [2:0]   mode_q;
  logic [11:0]  mctl_q;
  logic [7:0]   cctl_q;
  logic [7:0]   octl_q;
  logic [5:0]   stat_q;
  logic [5:0]   mask_q;
  logic [W-1:0] match_q [MCT_NMATCH];
  logic [W-1:0] cap_q   [MCT_NCAP];
  // bus address phase capture
  logic         wr_q;
  logic         rd_q;
  logic [7:0]   adr_q;
  logic         wr_ctrl;
  logic         wr_count;
  logic         wr_psc;
  logic         wr_pcnt;
  logic         wr_stat;
  // pin synchronisers, three stages each
  logic [2:0]   s0_q;
  logic [2:0]   s1_q;
  logic [2:0]   s2_q;
  logic [2:0]   prev_q;
  logic [2:0]   rise;
  logic [2:0]   fall;
  // event terms
  logic [3:0]   m_hit;
  logic [1:0]   c_hit;
  logic         tick;
  logic         pcnt_wrap;
  logic         cnt_clr;
  logic         do_stop;
  logic         ext_edge;
  logic         rst_hit;
  logic [5:0]   st_set;

  // bus front end: zero wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
    end else if (hready) begin
      wr_q  <= hsel & htrans[1] & hwrite;
      rd_q  <= hsel & htrans[1] & ~hwrite;
      adr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign wr_ctrl  = wr_q && adr_q == MCT_OFS_CTRL;
  assign wr_count = wr_q && adr_q == MCT_OFS_COUNT;
  assign wr_psc   = wr_q && adr_q == MCT_OFS_PSC;
  assign wr_pcnt  = wr_q && adr_q == MCT_OFS_PCNT;
  assign wr_stat  = wr_q && adr_q == MCT_OFS_STAT;

  // pin sync; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s0_q   <= 3'h0;
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      s0_q <= {count_in, cap_in};
      s1_q <= s0_q;
      s2_q <= s1_q;
      // a change counts once stages two and three agree
      for (int i = 0; i < 3; i++) begin
        if (s1_q[i] == s2_q[i]) prev_q[i] <= s2_q[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rise[i] = (s1_q[i] == s2_q[i]) & s2_q[i] & ~prev_q[i];
      fall[i] = (s1_q[i] == s2_q[i]) & ~s2_q[i] & prev_q[i];
    end
  end

  // external count source picks pin or capture pin
  always_comb begin
    logic r;
    logic f;
    r = mode_q[MCT_MODE_SEL] ? rise[0] : rise[2];
    f = mode_q[MCT_MODE_SEL] ? fall[0] : fall[2];
    case (mode_q[1:0])
      MCT_SRC_RISE: ext_edge = r;
      MCT_SRC_FALL: ext_edge = f;
      MCT_SRC_BOTH: ext_edge = r | f;
      default:      ext_edge = 1'b0;
    endcase
  end

  // capture and match detection
  genvar g;
  generate
    for (g = 0; g < MCT_NCAP; g++) begin : g_cap
      assign c_hit[g] = (cctl_q[4*g+MCT_CC_RISE] & rise[g]) |
                        (cctl_q[4*g+MCT_CC_FALL] & fall[g]);
    end
    for (g = 0; g < MCT_NMATCH; g++) begin : g_mat
      // compare only as the count is about to move, like a terminal count
      assign m_hit[g] = ctrl_q[MCT_CTRL_RUN] & tick &
                        (count_q == match_q[g]);
    end
  endgenerate

  // prescaler expiry gates counter; mode picks the tick source
  assign pcnt_wrap = (pcnt_q == psc_q);
  assign tick = (mode_q[1:0] == MCT_SRC_TIMER) ? pcnt_wrap : ext_edge;
  assign cnt_clr = |(c_hit & {cctl_q[4+MCT_CC_CLR], cctl_q[MCT_CC_CLR]});
  // stop and reset requests from any match that fires
  always_comb begin
    do_stop = 1'b0;
    rst_hit = 1'b0;
    for (int i = 0; i < MCT_NMATCH; i++) begin
      if (m_hit[i] && mctl_q[3*i+MCT_MC_STP]) do_stop = 1'b1;
      if (m_hit[i] && mctl_q[3*i+MCT_MC_RST]) rst_hit = 1'b1;
    end
  end

  // run and clear control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 2'h0;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[1:0];
    end else if (do_stop) begin
      ctrl_q[MCT_CTRL_RUN] <= 1'b0;
    end
  end

  // prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_q  <= W'(MCT_RST_VAL);
      pcnt_q <= W'(MCT_RST_VAL);
    end else begin
      if (wr_psc) psc_q <= hwdata[W-1:0];
      if (wr_pcnt) begin
        pcnt_q <= hwdata[W-1:0];
      end else if (ctrl_q[MCT_CTRL_CLR] || cnt_clr || do_stop) begin
        pcnt_q <= '0;
      end else if (ctrl_q[MCT_CTRL_RUN] &&
                   mode_q[1:0] == MCT_SRC_TIMER) begin
        pcnt_q <= pcnt_wrap ? '0 : pcnt_q + 1'b1;
      end
    end
  end

  // main counter; capture clear wins over match reset and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= W'(MCT_RST_VAL);
    end else begin
      if (wr_count) begin
        count_q <= hwdata[W-1:0];
      end else if (ctrl_q[MCT_CTRL_CLR] || cnt_clr) begin
        count_q <= '0;
      end else if (rst_hit) begin
        count_q <= '0;
      end else if (ctrl_q[MCT_CTRL_RUN] && tick && !do_stop) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // configuration and match registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 3'h0;
      mctl_q <= 12'h000;
      cctl_q <= 8'h00;
      octl_q <= 8'h00;
      mask_q <= 6'h00;
      for (int i = 0; i < MCT_NMATCH; i++) match_q[i] <= '0;
    end else if (wr_q) begin
      if (adr_q == MCT_OFS_MODE) mode_q <= hwdata[2:0];
      else if (adr_q == MCT_OFS_MCTL) mctl_q <= hwdata[11:0];
      else if (adr_q == MCT_OFS_CCTL) cctl_q <= hwdata[7:0];
      else if (adr_q == MCT_OFS_OCTL) octl_q <= hwdata[7:0];
      else if (adr_q == MCT_OFS_MASK) mask_q <= hwdata[5:0];
      else if (adr_q[7:4] == MCT_OFS_MATCH0[7:4])
        match_q[adr_q[3:2]] <= hwdata[W-1:0];
    end
  end

  // capture registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MCT_NCAP; i++) cap_q[i] <= '0;
    end else begin
      for (int i = 0; i < MCT_NCAP; i++) begin
        if (c_hit[i]) cap_q[i] <= count_q;
      end
    end
  end

  // status set terms, one per event source
  always_comb begin
    st_set = 6'h00;
    for (int i = 0; i < MCT_NMATCH; i++) begin
      st_set[i] = m_hit[i] & mctl_q[3*i+MCT_MC_IRQ];
    end
    for (int i = 0; i < MCT_NCAP; i++) begin
      st_set[MCT_ST_CAP+i] = c_hit[i] & cctl_q[4*i+MCT_CC_IRQ];
    end
  end

  // sticky status; a new event beats a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 6'h00;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? hwdata[5:0] : 6'h00)) | st_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else          irq <= |(stat_q & mask_q);
  end

  // match output actions; software may also preset the level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_out <= 4'h0;
    end else if (wr_q && adr_q == MCT_OFS_OUT) begin
      match_out <= hwdata[3:0];
    end else begin
      for (int i = 0; i < MCT_NMATCH; i++) begin
        if (m_hit[i]) begin
          case (octl_q[2*i+:2])
            MCT_ACT_LOW:  match_out[i] <= 1'b0;
            MCT_ACT_HIGH: match_out[i] <= 1'b1;
            MCT_ACT_TOG:  match_out[i] <= ~match_out[i];
            default:      match_out[i] <= match_out[i];
          endcase
        end
      end
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == MCT_OFS_CTRL) hrdata <= 32'(ctrl_q);
      else if (haddr[7:0] == MCT_OFS_COUNT) hrdata <= 32'(count_q);
      else if (haddr[7:0] == MCT_OFS_PSC) hrdata <= 32'(psc_q);
      else if (haddr[7:0] == MCT_OFS_PCNT) hrdata <= 32'(pcnt_q);
      else if (haddr[7:0] == MCT_OFS_MODE) hrdata <= 32'(mode_q);
      else if (haddr[7:0] == MCT_OFS_MCTL) hrdata <= 32'(mctl_q);
      else if (haddr[7:0] == MCT_OFS_CCTL) hrdata <= 32'(cctl_q);
      else if (haddr[7:0] == MCT_OFS_OCTL) hrdata <= 32'(octl_q);
      else if (haddr[7:0] == MCT_OFS_STAT) hrdata <= 32'(stat_q);
      else if (haddr[7:0] == MCT_OFS_MASK) hrdata <= 32'(mask_q);
      else if (haddr[7:0] == MCT_OFS_OUT) hrdata <= 32'(match_out);
      else if (haddr[7:4] == MCT_OFS_MATCH0[7:4])
        hrdata <= 32'(match_q[haddr[3:2]]);
      else if (haddr[7:3] == MCT_OFS_CAP0[7:3])
        hrdata <= 32'(cap_q[haddr[2]]);
      else hrdata <= 32'h0000_0000;
    end
  end

  logic unused;
  assign unused = ^{haddr[31:8], hsize, htrans[0], rd_q, hwdata[31:12]};
endmodule
`default_nettype wire

// ===== include/mct_pkg.sv
// package for the match/capture counter timer
// assumes a single 32-bit ahb-lite slave port, word aligned registers
package mct_pkg;
  // register byte offsets
  localparam logic [7:0] MCT_OFS_CTRL   = 8'h00; // bit0 run, bit1 clear
  localparam logic [7:0] MCT_OFS_COUNT  = 8'h04;
  localparam logic [7:0] MCT_OFS_PSC    = 8'h08; // prescale limit
  localparam logic [7:0] MCT_OFS_PCNT   = 8'h0c; // prescale counter
  localparam logic [7:0] MCT_OFS_MODE   = 8'h10;
  localparam logic [7:0] MCT_OFS_MCTL   = 8'h14; // match control
  localparam logic [7:0] MCT_OFS_CCTL   = 8'h18; // capture control
  localparam logic [7:0] MCT_OFS_OCTL   = 8'h1c; // output action
  localparam logic [7:0] MCT_OFS_STAT   = 8'h20;
  localparam logic [7:0] MCT_OFS_MASK   = 8'h24;
  localparam logic [7:0] MCT_OFS_OUT    = 8'h28;
  localparam logic [7:0] MCT_OFS_MATCH0 = 8'h30; // four words
  localparam logic [7:0] MCT_OFS_CAP0   = 8'h40; // two words
  // ctrl fields
  localparam int MCT_CTRL_RUN = 0;
  localparam int MCT_CTRL_CLR = 1;
  // mode fields: [1:0] source and count edge, [2] input select; capture edges in cctl
  localparam logic [1:0] MCT_SRC_TIMER = 2'h0;
  localparam logic [1:0] MCT_SRC_RISE  = 2'h1;
  localparam logic [1:0] MCT_SRC_FALL  = 2'h2;
  localparam logic [1:0] MCT_SRC_BOTH  = 2'h3;
  localparam int MCT_MODE_SEL = 2;
  // match control: 3 bits per match, irq/reset/stop
  localparam int MCT_MC_IRQ = 0;
  localparam int MCT_MC_RST = 1;
  localparam int MCT_MC_STP = 2;
  // capture control: 4 bits per channel, rise/fall/irq/clear
  localparam int MCT_CC_RISE = 0;
  localparam int MCT_CC_FALL = 1;
  localparam int MCT_CC_IRQ  = 2;
  localparam int MCT_CC_CLR  = 3;
  // output actions, 2 bits per output
  localparam logic [1:0] MCT_ACT_NONE = 2'h0;
  localparam logic [1:0] MCT_ACT_LOW  = 2'h1;
  localparam logic [1:0] MCT_ACT_HIGH = 2'h2;
  localparam logic [1:0] MCT_ACT_TOG  = 2'h3;
  // status: bits 3:0 match, 5:4 capture
  localparam int MCT_ST_CAP = 4;
  localparam int MCT_NMATCH = 4;
  localparam int MCT_NCAP   = 2;
  localparam logic [31:0] MCT_RST_VAL = 32'h0000_0000;
endpackage

// ===== tb/mct_timer_props.sv
// checker for the counter timer, bound to its top module
// assumes single-word ahb-lite writes at low byte addresses
`timescale 1ns/1ps
`default_nettype none
module mct_timer_chk
  import mct_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  match_out,
  input wire logic        irq
);
  logic       wa_q;
  logic       ra_q;
  logic [7:0] a_q;
  logic [7:0] mask_q;
  logic [7:0] oct_q;
  logic [2:0] wcnt_q;
  wire        req = hsel & htrans[1] & hready;
  wire        mask_z = mask_q == 8'h00;
  wire        oct_nz = oct_q != 8'h00;
  // shadow mask and action words so pins can be tied to their cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_q   <= 1'b0;
      ra_q   <= 1'b0;
      a_q    <= 8'h00;
      mask_q <= 8'h00;
      oct_q  <= 8'h00;
      wcnt_q <= 3'h7;
    end else begin
      wa_q <= req & hwrite;
      ra_q <= req & ~hwrite;
      a_q  <= haddr[7:0];
      if (wa_q && a_q == MCT_OFS_MASK) mask_q <= hwdata[7:0];
      if (wa_q && a_q == MCT_OFS_OCTL) oct_q <= hwdata[7:0];
      // saturates so a long quiet spell never wraps back to small
      if (req & hwrite) wcnt_q <= 3'h0;
      else if (wcnt_q != 3'h7) wcnt_q <= wcnt_q + 3'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rel;
    $rose(hresetn);
  endsequence
  sequence s_quiet;
    !irq && match_out == 4'h0;
  endsequence
  AST_READY: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_RDATA_STANDS: assert property ($changed(hrdata) |-> ra_q)
    else $error("read data moved without a read");
  AST_RDATA_HOLE: assert property
    (ra_q && (a_q == 8'h2c || a_q > 8'h47) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RST_QUIET: assert property (s_rel |-> s_quiet ##1 s_quiet)
    else $error("irq or match pins active after reset");
  AST_IRQ_MASKED: assert property (mask_z && $past(mask_z) |-> !irq)
    else $error("irq high with all flags masked");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> wcnt_q <= 3'h4)
    else $error("irq fell without a register write");
  AST_OUT_CAUSE: assert property ($changed(match_out) |->
    $past(oct_nz) || $past(oct_nz, 2) || wcnt_q <= 3'h3)
    else $error("match pins moved with no action set");
endmodule
bind mct_timer mct_timer_chk mct_timer_chk_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .match_out(match_out), .irq(irq));
`default_nettype wire

// ===== tb/mct_pins_model.sv
// pin-side model: drives capture and count pins, watches match outputs
// assumes its task is called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module mct_pins_model (
  input wire logic       hclk,
  output logic [1:0]     cap_in,
  output logic           count_in,
  input wire logic [3:0] match_out
);
  logic [3:0] seen_q; // last match levels, for viewing only
  always_ff @(posedge hclk) seen_q <= match_out;
  initial begin
    cap_in = 2'h0;
    count_in = 1'b0;
  end
  // eight cycles high then low: pins pass a synchroniser, short ones die
  task pulse(input int ch);
    if (ch == 2) count_in <= 1'b1;
    else cap_in[ch] <= 1'b1;
    repeat (8) @(posedge hclk);
    if (ch == 2) count_in <= 1'b0;
    else cap_in[ch] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the counter timer
// assumes zero-wait ahb-lite slave and the pin model beside it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mct_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
  logic        count_in, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv, v;
  logic [1:0]  htrans, cap_in;
  logic [2:0]  hsize;
  logic [3:0]  match_out;
  int          num_errors, checks, cyc;
  mct_timer #(.W(32)) mct_timer_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cap_in(cap_in),
    .count_in(count_in), .match_out(match_out), .irq(irq));
  mct_pins_model mct_pins_model_inst (.hclk(hclk), .cap_in(cap_in),
    .count_in(count_in), .match_out(match_out));
  always #10 hclk = ~hclk;
  // hang guard, well above the under a thousand cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b0, 32'h0);
    chk(n, e, rdv);
  endtask
  // stop, clear flags and settings between scenarios
  task setup;
    wr(MCT_OFS_CTRL, 32'h2);
    wr(MCT_OFS_STAT, 32'h3f);
    wr(MCT_OFS_MASK, 32'h0);
    wr(MCT_OFS_MCTL, 32'h0);
    wr(MCT_OFS_CCTL, 32'h0);
    wr(MCT_OFS_OCTL, 32'h0);
    wr(MCT_OFS_MODE, 32'h0);
    wr(MCT_OFS_PSC, 32'h0);
  endtask
  task t_reset;
    rdc(MCT_OFS_COUNT, 32'h0, "count");
    rdc(MCT_OFS_STAT, 32'h0, "stat");
    rdc(8'h80, 32'h0, "unmapped");
    rdc(8'h2c, 32'h0, "gap");
    chk("pins", 32'h0, {27'h0, irq, match_out});
  endtask
  task t_stop;
    setup();
    wr(MCT_OFS_PSC, 32'h1);
    wr(MCT_OFS_MATCH0, 32'h5);
    wr(MCT_OFS_MCTL, 32'h5);
    wr(MCT_OFS_MASK, 32'h1);
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (40) @(posedge hclk);
    rdc(MCT_OFS_COUNT, 32'h5, "stopped count");
    rdc(MCT_OFS_CTRL, 32'h0, "run bit");
    rdc(MCT_OFS_STAT, 32'h1, "match flag");
    chk("irq set", 32'h1, {31'h0, irq});
    wr(MCT_OFS_STAT, 32'h1);
    repeat (3) @(posedge hclk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  task t_wrap;
    setup();
    wr(MCT_OFS_MATCH0, 32'h1);
    wr(MCT_OFS_MATCH0 + 8'h4, 32'h3);
    wr(MCT_OFS_MCTL, 32'h19);
    wr(MCT_OFS_OCTL, {28'h0, MCT_ACT_TOG, 2'h0});
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (41) @(posedge hclk);
    wr(MCT_OFS_CTRL, 32'h0);
    bus(MCT_OFS_COUNT, 1'b0, 32'h0);
    chk("wrapped", 32'h1, {31'h0, rdv <= 32'h3});
    rdc(MCT_OFS_STAT, 32'h3, "both flags");
  endtask
  task t_actions;
    for (int i = 0; i < 4; i++) begin
      setup();
      wr(MCT_OFS_MATCH0, 32'h2);
      wr(MCT_OFS_MCTL, 32'h4);
      wr(MCT_OFS_OUT, {16'h0, 16'h10ff >> (4 * i)} & 32'hf);
      wr(MCT_OFS_OCTL, i);
      wr(MCT_OFS_CTRL, 32'h1);
      repeat (20) @(posedge hclk);
      chk("out pins", (32'h01ef >> (4 * i)) & 32'hf, {28'h0, match_out});
      rdc(MCT_OFS_STAT, 32'h0, "no flag");
    end
  endtask
  task t_capture;
    setup();
    wr(MCT_OFS_CCTL, 32'h52);
    wr(MCT_OFS_MASK, 32'h20);
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (20) @(posedge hclk);
    mct_pins_model_inst.pulse(1);
    mct_pins_model_inst.pulse(0);
    bus(MCT_OFS_CAP0 + 8'h4, 1'b0, 32'h0);
    v = rdv;
    bus(MCT_OFS_CAP0, 1'b0, 32'h0);
    chk("capture order", 32'h1, {31'h0, rdv > v && v > 32'h0});
    rdc(MCT_OFS_STAT, 32'h20, "capture flag");
    chk("capture irq", 32'h1, {31'h0, irq});
  endtask
  task t_clear;
    setup();
    wr(MCT_OFS_CCTL, 32'h9);
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (60) @(posedge hclk);
    mct_pins_model_inst.pulse(0);
    bus(MCT_OFS_COUNT, 1'b0, 32'h0);
    chk("cleared", 32'h1, {31'h0, rdv < 32'd30});
    bus(MCT_OFS_CAP0, 1'b0, 32'h0);
    chk("before clear", 32'h1, {31'h0, rdv > 32'd50});
  endtask
  task t_events;
    setup();
    wr(MCT_OFS_MODE, {30'h0, MCT_SRC_RISE});
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (5) mct_pins_model_inst.pulse(2);
    rdc(MCT_OFS_COUNT, 32'h5, "event count");
    setup();
    wr(MCT_OFS_MODE, {30'h0, MCT_SRC_FALL});
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (3) mct_pins_model_inst.pulse(2);
    rdc(MCT_OFS_COUNT, 32'h3, "fall count");
    // both edges of the first capture pin as count source
    setup();
    wr(MCT_OFS_MODE, {29'h0, 1'b1, MCT_SRC_BOTH});
    wr(MCT_OFS_CTRL, 32'h1);
    repeat (2) mct_pins_model_inst.pulse(0);
    rdc(MCT_OFS_COUNT, 32'h4, "both edges");
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_stop();
    t_wrap();
    t_actions();
    t_capture();
    t_clear();
    t_events();
    end_of_test();
  end
endmodule
`default_nettype wire
